/* acss_pkg.sv */
// Package of constants and types for the converter channel scan and select block.
package acss_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_SETUP  = 4'h0;  // Reference, clock and polarity setup.
  localparam logic [3:0] ADDR_CONFIG = 4'h1;  // Scan, channel and input mode.
  localparam logic [3:0] ADDR_CTRL   = 4'h2;  // Start pulse and stop pulse.
  localparam logic [3:0] ADDR_STATUS = 4'h3;  // Busy, reserved code, power state.
  localparam logic [3:0] ADDR_ROUTE  = 4'h4;  // Current positive and negative input.
  localparam logic [3:0] ADDR_COUNT  = 4'h5;  // Conversions done in the current request.

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SETUP_REFSEL_LSB = 4;   // Reference select, bits 6:4.
  localparam int SETUP_EXTCLK_BIT = 3;   // 1 selects the external conversion clock.
  localparam int SETUP_BIPOLAR    = 2;   // 1 selects bipolar coding.
  localparam int CFG_SCAN_LSB     = 5;   // Scan code, bits 6:5.
  localparam int CFG_CHAN_LSB     = 1;   // Channel code, bits 4:1.
  localparam int CFG_MODE_BIT     = 0;   // Input mode select.
  localparam int CTRL_START_BIT   = 0;
  localparam int CTRL_STOP_BIT    = 1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] SETUP_RESET  = 8'h00;  // Supply reference, internal clock, unipolar.
  localparam logic [7:0] CONFIG_RESET = 8'h61;  // Scan 11, input 0, single-ended.

  // ----------------------------------------------------------------
  // Codes and timing
  // ----------------------------------------------------------------
  localparam logic [1:0] SCAN_UP       = 2'h0;
  localparam logic [1:0] SCAN_REPEAT   = 2'h1;
  localparam logic [1:0] SCAN_UPPER    = 2'h2;
  localparam logic [1:0] SCAN_SINGLE   = 2'h3;
  localparam logic [3:0] REPEAT_COUNT  = 4'h8;
  localparam logic [3:0] CHAN_LAST     = 4'hB;   // Highest valid channel code.
  localparam logic [3:0] UPPER_START_4 = 4'h2;
  localparam logic [3:0] UPPER_START_8 = 4'h6;
  localparam logic [3:0] NO_INPUT      = 4'hF;   // Route code for ground or nothing.
  localparam int CONV_TIME_NS = 1000;          // One conversion slot.
  localparam int CLK_PERIOD_NS = 100;
  localparam logic [3:0] CONV_CYCLES = 4'((CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Variant: number of analog inputs.
  typedef enum logic [1:0]
  {
    ACSS_VAR_4  = 2'h0,
    ACSS_VAR_8  = 2'h1,
    ACSS_VAR_12 = 2'h2
  } acss_variant_t;

endpackage

/* acss_cfg_if.sv */
// Interface carrying the decoded configuration between the block's modules.
interface acss_cfg_if;
  logic [2:0] refsel;
  logic       input_mode_select;
  logic [3:0] chan_code;
  logic [1:0] scan_code;
  logic       ext_clk;
  logic       inref_on;
  logic       ref_pin_is_input;
  logic       ref_pin_drive;
  logic       ref_pin_ext;
  logic       auto_power_down;

  modport decoder
  (
    input  refsel,
    output inref_on,
    output ref_pin_is_input,
    output ref_pin_drive,
    output ref_pin_ext,
    output auto_power_down
  );

  modport core
  (
    output refsel,
    output input_mode_select,
    output chan_code,
    output scan_code,
    output ext_clk,
    input  inref_on,
    input  ref_pin_is_input,
    input  ref_pin_drive,
    input  ref_pin_ext,
    input  auto_power_down
  );
endinterface

/* acss_ref_decode.sv */
// Reference select decoder: source, shared pin role and internal reference power.
module acss_ref_decode
(
  acss_cfg_if.decoder cfg
);

  // Decode the three reference-select bits.
  always_comb
  begin
    cfg.inref_on         = cfg.refsel[2];
    cfg.ref_pin_is_input = ~cfg.refsel[1];
    cfg.ref_pin_ext      = ~cfg.refsel[2] & cfg.refsel[1];
    cfg.ref_pin_drive    = cfg.refsel[2] & cfg.refsel[1];
    cfg.auto_power_down  = cfg.refsel[2] & ~cfg.refsel[1] & ~cfg.refsel[0];
  end

endmodule

/* acss_top.sv */
// Top level of the converter channel scan and select control block.
// Summary of operation
// - Pseudo-differential codes pick adjacent even/odd pair.
// - Multi-channel differential scan follows low bit polarity.
// - Shared pin as reference reads as ground, except in the eight-input variant.
// - Smaller variants force upper channel bits zero.
// - Scan 00 converts input 0 up to selection.
// - Scan 01 converts selection eight times.
// - Four-input scan 10 runs from input 2.
// - Larger variants scan 10 from input 6.
// - Scan 11 converts selection once per request.
// - External clock with scan 01 or 11 repeats until master stops it.
// - Mode bit 1 single-ended, reset to 1.
// - Code 100 powers down analog while idle.
// - Power-up default: single-ended input 0, supply.
module acss_top
#(
  parameter acss_pkg::acss_variant_t VARIANT = acss_pkg::ACSS_VAR_12
)
(
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  input  wire logic [3:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  output logic      [3:0] pos_input_o,
  output logic      [3:0] neg_input_o,
  output logic            conv_start_o,
  output logic            busy_o,
  output logic            analog_on_o,
  output logic            inref_on_o,
  output logic            shared_input_ref_pin_oe_o,
  output logic            shared_input_ref_pin_ext_o,
  output logic            bipolar_o
);

  acss_cfg_if cfg ();

  typedef enum logic [1:0]
  {
    ACSS_IDLE = 2'h0,
    ACSS_CONV = 2'h1,
    ACSS_NEXT = 2'h2
  } acss_state_t;

  logic [7:0]  setup_q;
  logic [7:0]  config_q;
  acss_state_t state_q;
  logic [3:0]  cur_q;
  logic [3:0]  cnt_q;
  logic [3:0]  slot_q;
  logic [3:0]  first_ch;
  logic [3:0]  last_ch;
  logic [3:0]  sel_ch;
  logic [3:0]  pos_d;
  logic [3:0]  neg_d;
  logic        reserved_sel;
  logic        pair_mode;
  logic        start_req;
  logic        stop_req;
  logic        slot_done;
  logic        last_conv;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Force the channel bits that a smaller variant does not have to zero.
  function automatic logic [3:0] mask_chan(input logic [3:0] code);
    logic [3:0] m;
    m = code;
    if (VARIANT == acss_pkg::ACSS_VAR_4)
      m[3:2] = 2'h0;
    else if (VARIANT == acss_pkg::ACSS_VAR_8)
      m[3] = 1'h0;
    return m;
  endfunction

  // True for a channel code in the reserved range.
  function automatic logic is_reserved(input logic [3:0] code);
    return code > acss_pkg::CHAN_LAST;
  endfunction

  // Index of the input that carries the shared reference pin.
  function automatic logic [3:0] shared_pin();
    logic [3:0] p;
    p = acss_pkg::CHAN_LAST;
    if (VARIANT == acss_pkg::ACSS_VAR_4)
      p = 4'h3;
    return p;
  endfunction

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  assign start_req = wr_i & (addr_i == acss_pkg::ADDR_CTRL) & wdata_i[acss_pkg::CTRL_START_BIT];
  assign stop_req  = wr_i & (addr_i == acss_pkg::ADDR_CTRL) & wdata_i[acss_pkg::CTRL_STOP_BIT];

  // Setup register: reference select, clock source, polarity.
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      setup_q <= acss_pkg::SETUP_RESET;
    else if (wr_i && addr_i == acss_pkg::ADDR_SETUP)
      setup_q <= {1'h0, wdata_i[6:2], 2'h0};
  end

  // Configuration register: scan code, channel code, input mode.
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      config_q <= acss_pkg::CONFIG_RESET;
    else if (wr_i && addr_i == acss_pkg::ADDR_CONFIG)
      config_q <= {1'h0, wdata_i[6:5], mask_chan(wdata_i[4:1]), wdata_i[0]};
  end

  // Read data, registered one cycle after the strobe; unmapped reads give zero.
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      rdata_o <= 8'h00;
    else if (rd_i)
    begin
      unique case (addr_i)
        acss_pkg::ADDR_SETUP:  rdata_o <= setup_q;
        acss_pkg::ADDR_CONFIG: rdata_o <= config_q;
        acss_pkg::ADDR_STATUS: rdata_o <= {5'h00, analog_on_o, reserved_sel, busy_o};
        acss_pkg::ADDR_ROUTE:  rdata_o <= {pos_input_o, neg_input_o};
        acss_pkg::ADDR_COUNT:  rdata_o <= {4'h0, cnt_q};
        default:               rdata_o <= 8'h00;
      endcase
    end
    else
      rdata_o <= 8'h00;
  end

  // ----------------------------------------------------------------
  // Configuration decode
  // ----------------------------------------------------------------
  assign cfg.refsel            = setup_q[acss_pkg::SETUP_REFSEL_LSB +: 3];
  assign cfg.ext_clk           = setup_q[acss_pkg::SETUP_EXTCLK_BIT];
  assign cfg.input_mode_select = config_q[acss_pkg::CFG_MODE_BIT];
  assign cfg.chan_code         = config_q[acss_pkg::CFG_CHAN_LSB +: 4];
  assign cfg.scan_code         = config_q[acss_pkg::CFG_SCAN_LSB +: 2];

  acss_ref_decode u_ref
  (
    .cfg (cfg)
  );

  assign pair_mode    = ~cfg.input_mode_select;
  assign sel_ch       = cfg.chan_code;
  assign reserved_sel = is_reserved(sel_ch);

  // Scan range: first and last channel of a request.
  always_comb
  begin
    first_ch = sel_ch;
    last_ch  = sel_ch;
    unique case (cfg.scan_code)
      acss_pkg::SCAN_UP:
      begin
        first_ch = pair_mode ? {3'h0, sel_ch[0]} : 4'h0;
        last_ch  = sel_ch;
      end
      acss_pkg::SCAN_UPPER:
      begin
        if (VARIANT == acss_pkg::ACSS_VAR_4)
          first_ch = acss_pkg::UPPER_START_4 | {3'h0, pair_mode & sel_ch[0]};
        else
          first_ch = acss_pkg::UPPER_START_8 | {3'h0, pair_mode & sel_ch[0]};
        last_ch = (sel_ch < first_ch) ? first_ch : sel_ch;
      end
      acss_pkg::SCAN_REPEAT,
      acss_pkg::SCAN_SINGLE:
      begin
        first_ch = sel_ch;
        last_ch  = sel_ch;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Scan sequencer
  // ----------------------------------------------------------------
  assign slot_done = (slot_q == acss_pkg::CONV_CYCLES - 4'h1);

  // End of a request: external clock with scan 01 or 11 repeats until a stop, otherwise by scan code.
  always_comb
  begin
    if (cfg.ext_clk && cfg.scan_code[0])
      last_conv = 1'b0;
    else if (cfg.scan_code == acss_pkg::SCAN_REPEAT)
      last_conv = (cnt_q == acss_pkg::REPEAT_COUNT - 4'h1);
    else if (cfg.scan_code == acss_pkg::SCAN_SINGLE)
      last_conv = 1'b1;
    else
      last_conv = (cur_q >= last_ch) || (pair_mode && (cur_q + 4'h2 > last_ch));
  end

  // State machine: idle, converting one slot, stepping to the next channel.
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      state_q <= ACSS_IDLE;
    else if (stop_req)
      state_q <= ACSS_IDLE;
    else
    begin
      unique case (state_q)
        ACSS_IDLE: if (start_req && !reserved_sel) state_q <= ACSS_CONV;
        ACSS_CONV: if (slot_done) state_q <= last_conv ? ACSS_IDLE : ACSS_NEXT;
        ACSS_NEXT: state_q <= ACSS_CONV;
        default:   state_q <= ACSS_IDLE;
      endcase
    end
  end

  // Current channel: pairs step by two so the polarity of the low bit is kept.
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      cur_q <= 4'h0;
    else if (state_q == ACSS_IDLE && start_req)
      cur_q <= first_ch;
    else if (state_q == ACSS_NEXT && !cfg.scan_code[0])
      cur_q <= pair_mode ? cur_q + 4'h2 : cur_q + 4'h1;
  end

  // Conversions completed in this request.
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      cnt_q <= 4'h0;
    else if (state_q == ACSS_IDLE && start_req)
      cnt_q <= 4'h0;
    else if (state_q == ACSS_CONV && slot_done)
      cnt_q <= cnt_q + 4'h1;
  end

  // Cycle count inside one conversion slot.
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i || state_q != ACSS_CONV)
      slot_q <= 4'h0;
    else
      slot_q <= slot_q + 4'h1;
  end

  // ----------------------------------------------------------------
  // Input routing
  // ----------------------------------------------------------------
  always_comb
  begin
    pos_d = cur_q;
    neg_d = acss_pkg::NO_INPUT;
    if (is_reserved(cur_q))
      pos_d = acss_pkg::NO_INPUT;
    else if (pair_mode)
    begin
      pos_d = cur_q;
      neg_d = {cur_q[3:1], ~cur_q[0]};
    end
    if (!cfg.ref_pin_is_input && VARIANT != acss_pkg::ACSS_VAR_8)
    begin
      if (pos_d == shared_pin())
        pos_d = acss_pkg::NO_INPUT;
      if (neg_d == shared_pin())
        neg_d = acss_pkg::NO_INPUT;
    end
  end

  // Registered routing outputs, held at no input while idle.
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      pos_input_o <= acss_pkg::NO_INPUT;
      neg_input_o <= acss_pkg::NO_INPUT;
    end
    else if (state_q == ACSS_CONV)
    begin
      pos_input_o <= pos_d;
      neg_input_o <= neg_d;
    end
    else
    begin
      pos_input_o <= acss_pkg::NO_INPUT;
      neg_input_o <= acss_pkg::NO_INPUT;
    end
  end

  // Conversion start pulse in the second cycle of each slot, registered from its first cycle.
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      conv_start_o <= 1'b0;
    else
      conv_start_o <= (state_q == ACSS_CONV) && (slot_q == 4'h0);
  end

  // ----------------------------------------------------------------
  // Power and reference pin
  // ----------------------------------------------------------------
  assign busy_o = (state_q != ACSS_IDLE);

  // Analog section sleeps while idle under auto power-down.
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      analog_on_o <= 1'b1;
    else
      analog_on_o <= ~cfg.auto_power_down | busy_o | start_req;
  end

  // Internal reference power and shared pin role.
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      inref_on_o                 <= 1'b0;
      shared_input_ref_pin_oe_o  <= 1'b0;
      shared_input_ref_pin_ext_o <= 1'b0;
      bipolar_o                  <= 1'b0;
    end
    else
    begin
      inref_on_o                 <= cfg.inref_on & (~cfg.auto_power_down | busy_o);
      shared_input_ref_pin_oe_o  <= cfg.ref_pin_drive;
      shared_input_ref_pin_ext_o <= cfg.ref_pin_ext;
      bipolar_o                  <= setup_q[acss_pkg::SETUP_BIPOLAR];
    end
  end

endmodule

/* acss_checker.sv */
// Port checker for the converter channel scan and select block.
module acss_checker
#(
  parameter acss_pkg::acss_variant_t VARIANT = acss_pkg::ACSS_VAR_12
)
(
  input wire logic       core_clk_i,
  input wire logic       rst_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic [3:0] pos_input_o,
  input wire logic [3:0] neg_input_o,
  input wire logic       conv_start_o,
  input wire logic       busy_o,
  input wire logic       analog_on_o,
  input wire logic       inref_on_o,
  input wire logic       shared_input_ref_pin_oe_o,
  input wire logic       shared_input_ref_pin_ext_o,
  input wire logic       bipolar_o
);
  logic [7:0] setup_q;
  logic [7:0] cfg_q;
  logic [3:0] chan_mask;
  logic [3:0] shared_idx;
  logic       start_w;

  // ----------------------------------------------------------------
  // Shadow copies of the written setup and configuration bytes
  // ----------------------------------------------------------------
  // The variant decides which channel bits survive a write and where the shared pin sits.
  assign chan_mask = (VARIANT == acss_pkg::ACSS_VAR_4) ? 4'h3 :
                     (VARIANT == acss_pkg::ACSS_VAR_8) ? 4'h7 : 4'hF;
  assign shared_idx = (VARIANT == acss_pkg::ACSS_VAR_4) ? 4'h3 : 4'hB;
  assign start_w = wr_i && addr_i == acss_pkg::ADDR_CTRL && wdata_i[0] && !wdata_i[1];

  // Shadow registers follow the bus writes on the same edge as the design.
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      setup_q <= acss_pkg::SETUP_RESET;
      cfg_q   <= acss_pkg::CONFIG_RESET;
    end
    else if (wr_i && addr_i == acss_pkg::ADDR_SETUP)
      setup_q <= wdata_i;
    else if (wr_i && addr_i == acss_pkg::ADDR_CONFIG)
      cfg_q <= {wdata_i[7:5], wdata_i[4:1] & chan_mask, wdata_i[0]};
  end

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_rd_idle; !rd_i |=> rdata_o == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero outside answer");
  property p_start; start_w && !busy_o && cfg_q[4:1] <= acss_pkg::CHAN_LAST
    |=> busy_o ##1 conv_start_o; endproperty
  a_start: assert property (p_start) else $error("start did not begin a slot");
  property p_reserved; start_w && !busy_o && cfg_q[4:1] > acss_pkg::CHAN_LAST |=> !busy_o;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved code started");
  property p_hold; conv_start_o |=> ($stable(pos_input_o) || !busy_o) [*8]; endproperty
  a_hold: assert property (p_hold) else $error("route moved inside a slot");
  property p_idle; !busy_o && $past(!busy_o) |->
    pos_input_o == acss_pkg::NO_INPUT && neg_input_o == acss_pkg::NO_INPUT; endproperty
  a_idle: assert property (p_idle) else $error("route driven while idle");
  property p_pair; conv_start_o && !cfg_q[0] && pos_input_o != acss_pkg::NO_INPUT &&
    neg_input_o != acss_pkg::NO_INPUT |-> neg_input_o == (pos_input_o ^ 4'h1); endproperty
  a_pair: assert property (p_pair) else $error("pair not adjacent");
  property p_single; conv_start_o && cfg_q[0] |-> neg_input_o == acss_pkg::NO_INPUT;
  endproperty
  a_single: assert property (p_single) else $error("single-ended not against ground");
  property p_shared; conv_start_o && setup_q[5] && VARIANT != acss_pkg::ACSS_VAR_8 |->
    pos_input_o != shared_idx && neg_input_o != shared_idx; endproperty
  a_shared: assert property (p_shared) else $error("shared pin routed as input");
  property p_pin; $stable(setup_q) |-> shared_input_ref_pin_oe_o == (setup_q[6:5] == 2'h3)
    && shared_input_ref_pin_ext_o == (setup_q[6:5] == 2'h1); endproperty
  a_pin: assert property (p_pin) else $error("shared pin role wrong");
  property p_inref; $stable(setup_q) && setup_q[6:4] != 3'h4 |-> inref_on_o == setup_q[6];
  endproperty
  a_inref: assert property (p_inref) else $error("internal reference state wrong");
  property p_autopd; $stable(setup_q) && !busy_o && $past(!busy_o) |->
    analog_on_o == (setup_q[6:4] != 3'h4); endproperty
  a_autopd: assert property (p_autopd) else $error("idle power state wrong");
  property p_bipolar; $stable(setup_q) |-> bipolar_o == setup_q[2]; endproperty
  a_bipolar: assert property (p_bipolar) else $error("bipolar output wrong");
endmodule

bind acss_top acss_checker #(.VARIANT(VARIANT)) acss_checker_inst (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pos_input_o(pos_input_o),
  .neg_input_o(neg_input_o), .conv_start_o(conv_start_o), .busy_o(busy_o),
  .analog_on_o(analog_on_o), .inref_on_o(inref_on_o),
  .shared_input_ref_pin_oe_o(shared_input_ref_pin_oe_o),
  .shared_input_ref_pin_ext_o(shared_input_ref_pin_ext_o), .bipolar_o(bipolar_o));

/* acss_master.sv */
// Register bus master model that configures the block and reads it back.
module acss_master
(
  input  wire logic       core_clk_i,
  input  wire logic [7:0] rdata_i,
  output logic      [3:0] addr_o,
  output logic      [7:0] wdata_o,
  output logic            wr_o,
  output logic            rd_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // Bus lines start idle at time zero.
  initial
  begin
    addr_o <= 4'h0;
    wdata_o <= 8'h00;
    wr_o <= 1'b0;
    rd_o <= 1'b0;
  end

  // One-cycle write; lines show the inverse afterwards so no stale value helps.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge core_clk_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask

  // One-cycle read; the answer is taken in the cycle after the strobe.
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge core_clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    @(negedge core_clk_i);
    d = rdata_i;
  endtask

  // The master ends external-clock conversions with a stop.
  task automatic stop();
    wr(acss_pkg::ADDR_CTRL, 8'h02);
  endtask
endmodule

/* tb_acss_top.sv */
// Self-checking testbench of the converter channel scan and select block.
module tb_acss_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic       core_clk_i, rst_i, wr, rd, v4, v8, cs12, cs4, busy12, busy4;
  logic       an, inref, oe, ext, bip;
  logic [3:0] addr, pos12, neg12, pos4, neg4;
  logic [7:0] wdata, rd12, rd4, rd8, d;
  logic [7:0] exp_q[$];
  logic [7:0] got_q[$];
  int         failures, n_tests, i, cnt;

  acss_top acss_top_inst (.core_clk_i(core_clk_i), .rst_i(rst_i), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rd12), .pos_input_o(pos12),
    .neg_input_o(neg12), .conv_start_o(cs12), .busy_o(busy12), .analog_on_o(an),
    .inref_on_o(inref), .shared_input_ref_pin_oe_o(oe), .shared_input_ref_pin_ext_o(ext),
    .bipolar_o(bip));
  acss_top #(.VARIANT(acss_pkg::ACSS_VAR_4)) acss_top_4_inst (.core_clk_i(core_clk_i),
    .rst_i(rst_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rd4),
    .pos_input_o(pos4), .neg_input_o(neg4), .conv_start_o(cs4), .busy_o(busy4),
    .analog_on_o(), .inref_on_o(), .shared_input_ref_pin_oe_o(),
    .shared_input_ref_pin_ext_o(), .bipolar_o());
  acss_top #(.VARIANT(acss_pkg::ACSS_VAR_8)) acss_top_8_inst (.core_clk_i(core_clk_i),
    .rst_i(rst_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rd8),
    .pos_input_o(), .neg_input_o(), .conv_start_o(), .busy_o(), .analog_on_o(),
    .inref_on_o(), .shared_input_ref_pin_oe_o(), .shared_input_ref_pin_ext_o(),
    .bipolar_o());
  acss_master acss_master_inst (.core_clk_i(core_clk_i),
    .rdata_i(v8 ? rd8 : (v4 ? rd4 : rd12)),
    .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));

  // Free-running bench clock of 100 ns.
  initial
  begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end

  // Compare, count and report one value.
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Verdict and end of run.
  task automatic results();
    if (failures == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Expected list of {positive, negative} routes for one request.
  function automatic void plan(input logic v, input logic md, input logic [3:0] chi,
                               input logic [1:0] sc, input logic r1);
    logic [3:0] ch, p, pp, n, lo, hi, sh, st;
    int k;
    exp_q.delete();
    ch = v ? (chi & 4'h3) : chi;
    sh = v ? 4'h3 : 4'hB;
    st = md ? 4'h1 : 4'h2;
    lo = (sc == acss_pkg::SCAN_UPPER) ? (v ? 4'h2 : 4'h6) : 4'h0;
    lo = md ? lo : (lo | {3'h0, ch[0]});
    hi = (ch > lo) ? ch : lo;
    if (sc[0])
    begin
      lo = ch;
      hi = ch;
    end
    for (p = lo; p <= hi; p = p + st)
      for (k = 0; k < ((sc == acss_pkg::SCAN_REPEAT) ? 8 : 1); k++)
      begin
        n = md ? 4'hF : (p ^ 4'h1);
        pp = (r1 && p == sh) ? 4'hF : p;
        n = (r1 && n == sh) ? 4'hF : n;
        exp_q.push_back({pp, n});
      end
  endfunction

  // Configure, start, and collect the routes of every slot of one request.
  task automatic run(input logic v, input logic md, input logic [3:0] ch,
                     input logic [1:0] sc, input logic r1);
    logic went;
    v4 = v;
    went = 1'b0;
    got_q.delete();
    acss_master_inst.wr(acss_pkg::ADDR_SETUP, {2'h0, r1, 5'h00});
    acss_master_inst.wr(acss_pkg::ADDR_CONFIG, {1'b0, sc, ch, md});
    plan(v, md, ch, sc, r1);
    acss_master_inst.wr(acss_pkg::ADDR_CTRL, 8'h01);
    for (i = 0; i < 400 && !(went && !busy12 && !busy4); i++)
    begin
      @(negedge core_clk_i);
      if (v ? cs4 : cs12)
        got_q.push_back(v ? {pos4, neg4} : {pos12, neg12});
      went = went | busy12 | busy4;
    end
    if (i >= 400)
    begin
      failures++;
      results();
    end
    else
    begin
      check("slots", 8'(got_q.size()), 8'(exp_q.size()));
      for (i = 0; i < exp_q.size() && i < got_q.size(); i++)
        check("route", got_q[i], exp_q[i]);
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    rst_i = 1'b1;
    v4 = 1'b0;
    v8 = 1'b0;
    failures = 0;
    n_tests = 0;
    void'($urandom(58));
    repeat (16) @(posedge core_clk_i);
    rst_i <= 1'b0;
    acss_master_inst.rd(acss_pkg::ADDR_CONFIG, d);
    check("config reset", d, 8'h61);
    acss_master_inst.rd(acss_pkg::ADDR_SETUP, d);
    check("setup reset", d, 8'h00);
    acss_master_inst.rd(acss_pkg::ADDR_ROUTE, d);
    check("route idle", d, 8'hFF);
    acss_master_inst.rd(4'hF, d);
    check("unmapped", d, 8'h00);
    check("power reset", {6'h00, an, inref}, 8'h02);
    acss_master_inst.wr(acss_pkg::ADDR_CONFIG, 8'h1F);
    v4 = 1'b1;
    acss_master_inst.rd(acss_pkg::ADDR_CONFIG, d);
    check("mask 4", d, 8'h07);
    v4 = 1'b0;
    v8 = 1'b1;
    acss_master_inst.rd(acss_pkg::ADDR_CONFIG, d);
    check("mask 8", d, 8'h0F);
    v8 = 1'b0;
    v4 = 1'b0;
    acss_master_inst.rd(acss_pkg::ADDR_CONFIG, d);
    check("mask 12", d, 8'h1F);
    acss_master_inst.wr(acss_pkg::ADDR_CONFIG, 8'h78);
    acss_master_inst.wr(acss_pkg::ADDR_CTRL, 8'h01);
    repeat (3) @(negedge core_clk_i);
    check("reserved", {7'h00, busy12}, 8'h00);
    for (cnt = 0; cnt < 8; cnt++)
    begin
      acss_master_inst.wr(acss_pkg::ADDR_SETUP, {1'b0, 3'(cnt), 1'b0, cnt[0], 2'h0});
      repeat (2) @(negedge core_clk_i);
      check("ref", {4'h0, oe, ext, an, bip}, {4'h0, cnt[2:1] == 2'h3, cnt[2:1] == 2'h1,
                    cnt != 4, cnt[0]});
      check("inref", {7'h00, inref}, {7'h00, cnt[2] && cnt != 4});
    end
    run(1'b0, 1'b0, 4'hA, acss_pkg::SCAN_UP, 1'b0);
    run(1'b0, 1'b0, 4'hB, acss_pkg::SCAN_UP, 1'b1);
    run(1'b1, 1'b1, 4'h0, acss_pkg::SCAN_UPPER, 1'b0);
    run(1'b1, 1'b1, 4'h3, acss_pkg::SCAN_UPPER, 1'b1);
    run(1'b0, 1'b1, 4'h5, acss_pkg::SCAN_UPPER, 1'b0);
    run(1'b0, 1'b0, 4'h9, acss_pkg::SCAN_UPPER, 1'b0);
    for (cnt = 0; cnt < 16; cnt++)
      run(($urandom % 4) == 0, 1'($urandom), 4'($urandom % 12), 2'($urandom), 1'($urandom));
    acss_master_inst.wr(acss_pkg::ADDR_SETUP, 8'h08);
    acss_master_inst.wr(acss_pkg::ADDR_CONFIG, 8'h65);
    acss_master_inst.wr(acss_pkg::ADDR_CTRL, 8'h01);
    cnt = 0;
    repeat (60)
    begin
      @(negedge core_clk_i);
      cnt = cnt + int'(cs12);
    end
    check("ext run", {7'h00, busy12 && cnt >= 5}, 8'h01);
    acss_master_inst.stop();
    repeat (2) @(negedge core_clk_i);
    check("ext stop", {6'h00, busy12, busy4}, 8'h00);
    results();
  end
endmodule
